// *** rtl/dac_link_host.sv ***
// two-wire bus master that writes and reads the dac input register
`timescale 1ns/10ps
`include "dac_link_map.svh"
module dac_link_host #(
  parameter int unsigned QUARTER_CYCLES = `DAC_LINK_QUARTER_CYC
) (
  // system
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET_N,
  // serial link
  dac_link_if.host                         LINK,
  // request
  input  wire logic                        REQ_VALID,
  input  wire logic                        REQ_READ,
  input  wire logic [6:0]                  REQ_ADDR,
  input  wire dac_link_pkg::shift_word_t   REQ_WDATA,
  output logic                             REQ_READY,
  // answer
  output logic                             RSP_VALID,
  output logic                             RSP_NAK,
  output dac_link_pkg::shift_word_t        RSP_RDATA
);
  import dac_link_pkg::*;

  host_state_t st_q;
  host_state_t st_d;
  logic [7:0]  qcnt_q;
  logic [7:0]  qcnt_d;
  logic [1:0]  ph_q;
  logic [1:0]  ph_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [1:0]  byte_q;
  logic [1:0]  byte_d;
  logic [23:0] tx_q;
  logic [23:0] tx_d;
  shift_word_t rx_q;
  shift_word_t rx_d;
  logic        rd_q;
  logic        rd_d;
  logic        nak_q;
  logic        nak_d;
  logic        scl_oe_q;
  logic        scl_oe_d;
  logic        sda_oe_q;
  logic        sda_oe_d;
  logic        rsp_q;
  logic        rsp_d;
  shift_word_t rdata_q;
  shift_word_t rdata_d;
  logic [2:0]  sda_sync_q;
  logic        sda_f_q;
  logic        sda_f_d;
  logic        tick;
  logic        own_byte;

  always_comb begin
    sda_f_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
  end

  assign tick     = (qcnt_q == 8'(QUARTER_CYCLES - 1));
  // bytes the master sends: address byte, and data bytes of a write
  assign own_byte = (byte_q == 2'h0) | ~rd_q;

  always_comb begin
    st_d     = st_q;
    qcnt_d   = qcnt_q;
    ph_d     = ph_q;
    bit_d    = bit_q;
    byte_d   = byte_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    rd_d     = rd_q;
    nak_d    = nak_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rsp_d    = 1'b0;
    rdata_d  = rdata_q;
    if (st_q == HOST_IDLE) begin
      qcnt_d = 8'h00;
      ph_d   = 2'h0;
      if (REQ_VALID) begin
        st_d   = HOST_START;
        tx_d   = {REQ_ADDR, REQ_READ, REQ_WDATA};
        rd_d   = REQ_READ;
        nak_d  = 1'b0;
        bit_d  = 4'h0;
        byte_d = 2'h0;
      end
    end else begin
      qcnt_d = tick ? 8'h00 : qcnt_q + 8'h01;
      if (tick) begin
        ph_d = ph_q + 2'h1;
        unique case (st_q)
          HOST_START: begin
            if (ph_q == 2'h1) sda_oe_d = 1'b1;
            if (ph_q == 2'h3) begin
              scl_oe_d = 1'b1;
              st_d     = HOST_BITS;
            end
          end
          HOST_BITS: begin
            unique case (ph_q)
              2'h0: begin
                if (bit_q < `DAC_LINK_ACK_SLOT) begin
                  sda_oe_d = own_byte & ~tx_q[23];
                end else begin
                  // acknowledge each read byte, release for the slave
                  sda_oe_d = ~own_byte;
                end
              end
              2'h1: scl_oe_d = 1'b0;
              2'h2: begin
                if (bit_q < `DAC_LINK_ACK_SLOT) begin
                  if (!own_byte) rx_d = {rx_q[14:0], sda_f_q};
                end else if (own_byte) begin
                  nak_d = nak_q | sda_f_q;
                end
              end
              2'h3: begin
                scl_oe_d = 1'b1;
                if (bit_q < `DAC_LINK_ACK_SLOT) begin
                  bit_d = bit_q + 4'h1;
                  tx_d  = {tx_q[22:0], 1'b0};
                end else begin
                  bit_d  = 4'h0;
                  byte_d = byte_q + 2'h1;
                  if (byte_q == `DAC_LINK_DATA_BYTES) begin
                    st_d = HOST_STOP;
                  end
                end
              end
            endcase
          end
          HOST_STOP: begin
            unique case (ph_q)
              2'h0: sda_oe_d = 1'b1;
              2'h1: scl_oe_d = 1'b0;
              2'h2: sda_oe_d = 1'b0;
              2'h3: begin
                st_d    = HOST_IDLE;
                rsp_d   = 1'b1;
                rdata_d = rx_q;
              end
            endcase
          end
          default: st_d = HOST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q       <= HOST_IDLE;
      qcnt_q     <= 8'h00;
      ph_q       <= 2'h0;
      bit_q      <= 4'h0;
      byte_q     <= 2'h0;
      tx_q       <= 24'h000000;
      rx_q       <= 16'h0000;
      rd_q       <= 1'b0;
      nak_q      <= 1'b0;
      scl_oe_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
      rsp_q      <= 1'b0;
      rdata_q    <= 16'h0000;
      sda_sync_q <= 3'h7;
      sda_f_q    <= 1'b1;
    end else begin
      st_q       <= st_d;
      qcnt_q     <= qcnt_d;
      ph_q       <= ph_d;
      bit_q      <= bit_d;
      byte_q     <= byte_d;
      tx_q       <= tx_d;
      rx_q       <= rx_d;
      rd_q       <= rd_d;
      nak_q      <= nak_d;
      scl_oe_q   <= scl_oe_d;
      sda_oe_q   <= sda_oe_d;
      rsp_q      <= rsp_d;
      rdata_q    <= rdata_d;
      sda_sync_q <= {sda_sync_q[1:0], LINK.sda_in};
      sda_f_q    <= sda_f_d;
    end
  end

  // both lines are pulled low or released, never driven high
  assign LINK.scl_out_host = 1'b0;
  assign LINK.sda_out_host = 1'b0;
  assign LINK.scl_oe_host  = scl_oe_q;
  assign LINK.sda_oe_host  = sda_oe_q;

  assign REQ_READY = (st_q == HOST_IDLE);
  assign RSP_VALID = rsp_q;
  assign RSP_NAK   = nak_q;
  assign RSP_RDATA = rdata_q;

endmodule

// *** rtl/dac_link_map.svh ***
// constants for the two-wire current dac slave port and its master
`ifndef DAC_LINK_MAP_SVH
`define DAC_LINK_MAP_SVH

// system clock and highest serial bit rate
`define DAC_LINK_SYS_CLK_KHZ    50000
`define DAC_LINK_MAX_RATE_KHZ   400
// quarter of one bit period in system clocks, rounded up (slower is safe)
`define DAC_LINK_QUARTER_CYC \
  ((`DAC_LINK_SYS_CLK_KHZ + 4 * `DAC_LINK_MAX_RATE_KHZ - 1) / \
   (4 * `DAC_LINK_MAX_RATE_KHZ))

// slave address 0001100, the two low address bits are ignored
`define DAC_LINK_ADDR7          7'h0c
`define DAC_LINK_ADDR_MATCH     5'h03
`define DAC_LINK_ADDR_TOP       7
`define DAC_LINK_ADDR_LOW       3

// input register layout
`define DAC_LINK_REG_RESET      16'h0000
`define DAC_LINK_PD_BIT         15
`define DAC_LINK_CODE_MSB       13
`define DAC_LINK_CODE_LSB       4

// framing
`define DAC_LINK_ACK_SLOT       4'h8
`define DAC_LINK_LAST_SLOT      4'h9
`define DAC_LINK_DATA_BYTES     2'h2

`endif

// *** rtl/dac_link_pkg.sv ***
// types shared by both ends of the two-wire dac link
package dac_link_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_WDATA,
    DEV_RDATA,
    DEV_IGNORE
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_START,
    HOST_BITS,
    HOST_STOP
  } host_state_t;

  typedef logic [15:0] shift_word_t;
  typedef logic [9:0]  current_code_t;

endpackage

// *** rtl/dac_link_if.sv ***
// open-drain clock and data wires between the bus master and the dac port
`timescale 1ns/10ps
interface dac_link_if;
  logic scl_out_host;
  logic scl_oe_host;
  logic sda_out_host;
  logic sda_oe_host;
  logic sda_out_dev;
  logic sda_oe_dev;
  logic scl_in;
  logic sda_in;

  // a line is low while any driver pulls it, pull-ups make it high otherwise
  assign scl_in = ~(scl_oe_host & ~scl_out_host);
  assign sda_in = ~((sda_oe_host & ~sda_out_host) |
                    (sda_oe_dev & ~sda_out_dev));

  modport host (
    input  scl_in,
    input  sda_in,
    output scl_out_host,
    output scl_oe_host,
    output sda_out_host,
    output sda_oe_host
  );

  modport device (
    input  scl_in,
    input  sda_in,
    output sda_out_dev,
    output sda_oe_dev
  );
endinterface

// *** rtl/dac_link_device.sv ***
// serial slave port of the current-sink dac: input and dac registers
`timescale 1ns/10ps
`include "dac_link_map.svh"
//
// Notes on behaviour
// - transfers work up to 400 kHz bit rate
// - finished read clears the input register
// - lines are only pulled low or released
// - idle bus leaves both lines high
// - start condition begins address shifting
// - seven address bits then direction bit
// - answer addresses 0x0c to 0x0f only
// - acknowledge low through the ninth pulse
// - data high-phase changes mean start/stop
// - two acknowledged data bytes per transfer
// - stop condition returns to waiting state
// - write high byte first, msb first
// - complete write loads the dac register
// - bit fifteen is software power-down
// - bits thirteen to four are current code
// - read returns same layout and order
// - power-down pin acts without any clock
module dac_link_device (
  // system
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET_N,
  // serial link
  dac_link_if.device                       LINK,
  // analog core
  input  wire logic                        PD_PIN,
  output logic                             POWER_DOWN,
  output dac_link_pkg::current_code_t      CURRENT_CODE,
  output dac_link_pkg::shift_word_t        INPUT_SHIFT_BITS
);
  import dac_link_pkg::*;

  // bit of the input register sent at position idx of byte hi or lo
  function automatic logic tx_bit(input shift_word_t r,
                                  input logic        hi,
                                  input logic [2:0]  idx);
    tx_bit = r[{hi, ~idx}];
  endfunction

  // pin synchronisers, three stages each
  logic [2:0]  scl_sync_q;
  logic [2:0]  sda_sync_q;
  logic        scl_f_q;
  logic        sda_f_q;
  logic        scl_f_d;
  logic        sda_f_d;

  dev_state_t  st_q;
  dev_state_t  st_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [1:0]  byte_q;
  logic [1:0]  byte_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic        rw_q;
  logic        rw_d;
  logic        oe_q;
  logic        oe_d;
  logic        rd_done_q;
  logic        rd_done_d;
  shift_word_t in_reg_q;
  shift_word_t in_reg_d;
  shift_word_t dac_q;
  shift_word_t dac_d;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;

  // a change counts once the second and third stages agree
  always_comb begin
    scl_f_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
    sda_f_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], LINK.scl_in};
      sda_sync_q <= {sda_sync_q[1:0], LINK.sda_in};
      scl_f_q    <= scl_f_d;
      sda_f_q    <= sda_f_d;
    end
  end

  // edges of the filtered lines; 400 kHz leaves many clocks per phase
  assign scl_rise   = scl_f_d & ~scl_f_q;
  assign scl_fall   = ~scl_f_d & scl_f_q;
  // data moving while the clock stays high is a start or a stop
  assign start_cond = scl_f_d & scl_f_q & sda_f_q & ~sda_f_d;
  assign stop_cond  = scl_f_d & scl_f_q & ~sda_f_q & sda_f_d;

  always_comb begin
    st_d      = st_q;
    bit_d     = bit_q;
    byte_d    = byte_q;
    shift_d   = shift_q;
    rw_d      = rw_q;
    oe_d      = oe_q;
    rd_done_d = rd_done_q;
    in_reg_d  = in_reg_q;
    dac_d     = dac_q;
    if (start_cond) begin
      // repeated start is taken from any state
      st_d   = DEV_ADDR;
      bit_d  = 4'h0;
      byte_d = 2'h0;
      oe_d   = 1'b0;
    end else if (stop_cond) begin
      st_d = DEV_IDLE;
      oe_d = 1'b0;
      if (rd_done_q) begin
        in_reg_d  = `DAC_LINK_REG_RESET;
        rd_done_d = 1'b0;
      end
    end else if (st_q != DEV_IDLE && st_q != DEV_IGNORE) begin
      if (scl_rise) begin
        if (bit_q < `DAC_LINK_ACK_SLOT) begin
          shift_d = {shift_q[6:0], sda_f_q};
        end
        if (bit_q != `DAC_LINK_LAST_SLOT) begin
          bit_d = bit_q + 4'h1;
        end
      end
      if (scl_fall) begin
        if (bit_q == `DAC_LINK_ACK_SLOT) begin
          // eighth bit just ended: acknowledge slot opens
          if (st_q == DEV_ADDR) begin
            if (shift_q[`DAC_LINK_ADDR_TOP:`DAC_LINK_ADDR_LOW] ==
                `DAC_LINK_ADDR_MATCH) begin
              oe_d = 1'b1;
              rw_d = shift_q[0];
            end else begin
              st_d = DEV_IGNORE;
              oe_d = 1'b0;
            end
          end else if (st_q == DEV_WDATA) begin
            oe_d = 1'b1;
            if (byte_q == 2'h0) begin
              in_reg_d[15:8] = shift_q;
            end else begin
              in_reg_d[7:0] = shift_q;
              dac_d         = {in_reg_q[15:8], shift_q};
            end
          end else begin
            // the master answers read bytes
            oe_d = 1'b0;
          end
        end else if (bit_q == `DAC_LINK_LAST_SLOT) begin
          // ninth pulse over: release or drive the next read bit
          bit_d = 4'h0;
          if (st_q == DEV_ADDR) begin
            byte_d = 2'h0;
            if (rw_q) begin
              st_d = DEV_RDATA;
              oe_d = ~tx_bit(in_reg_q, 1'b1, 3'h0);
            end else begin
              st_d = DEV_WDATA;
              oe_d = 1'b0;
            end
          end else begin
            byte_d = byte_q + 2'h1;
            if (byte_q + 2'h1 == `DAC_LINK_DATA_BYTES) begin
              // further bytes are not answered until the next start
              st_d      = DEV_IGNORE;
              oe_d      = 1'b0;
              rd_done_d = (st_q == DEV_RDATA);
            end else if (st_q == DEV_RDATA) begin
              oe_d = ~tx_bit(in_reg_q, 1'b0, 3'h0);
            end else begin
              oe_d = 1'b0;
            end
          end
        end else if (st_q == DEV_RDATA) begin
          // read bits change only while the clock is low
          oe_d = ~tx_bit(in_reg_q, ~byte_q[0], bit_q[2:0]);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q      <= DEV_IDLE;
      bit_q     <= 4'h0;
      byte_q    <= 2'h0;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      oe_q      <= 1'b0;
      rd_done_q <= 1'b0;
      in_reg_q  <= `DAC_LINK_REG_RESET;
      dac_q     <= `DAC_LINK_REG_RESET;
    end else begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      byte_q    <= byte_d;
      shift_q   <= shift_d;
      rw_q      <= rw_d;
      oe_q      <= oe_d;
      rd_done_q <= rd_done_d;
      in_reg_q  <= in_reg_d;
      dac_q     <= dac_d;
    end
  end

  // data is only ever pulled low
  assign LINK.sda_out_dev = 1'b0;
  assign LINK.sda_oe_dev  = oe_q;

  // pin path is purely combinational so it acts with no clock running
  assign POWER_DOWN = PD_PIN | dac_q[`DAC_LINK_PD_BIT];
  // bit 14 and bits 3..0 never reach the core
  assign CURRENT_CODE =
    dac_q[`DAC_LINK_CODE_MSB:`DAC_LINK_CODE_LSB];
  assign INPUT_SHIFT_BITS = in_reg_q;

endmodule

// *** test/dac_link_monitor.sv ***
// concurrent checks on the open-drain wires of the dac link
`timescale 1ns/10ps
module dac_link_monitor (
  // system
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // master drivers
  input wire logic scl_out_host,
  input wire logic scl_oe_host,
  input wire logic sda_out_host,
  input wire logic sda_oe_host,
  // device drivers
  input wire logic sda_out_dev,
  input wire logic sda_oe_dev,
  // wired levels
  input wire logic scl_in,
  input wire logic sda_in
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_dev_sda_open: assert property (sda_oe_dev |-> !sda_out_dev)
    else $error("device drives data line high");
  a_host_scl_open: assert property (scl_oe_host |-> !scl_out_host)
    else $error("master drives clock line high");
  a_host_sda_open: assert property (sda_oe_host |-> !sda_out_host)
    else $error("master drives data line high");
  a_idle_after_reset: assert property ($rose(RESET_N) |->
    scl_in && sda_in && !sda_oe_dev && !scl_oe_host)
    else $error("lines not released after reset");
  a_dev_data_steady: assert property (scl_in && $past(scl_in)
    |-> $stable(sda_oe_dev))
    else $error("device moved data while clock high");
  a_ack_after_fall: assert property ($rose(sda_oe_dev) |->
    !$past(scl_in, 2) && $past(scl_in, 8))
    else $error("device pull not placed after clock fall");
  a_ack_held_high: assert property ($rose(scl_in) && sda_oe_dev
    |-> sda_oe_dev [*4])
    else $error("device pull released in clock high phase");
  a_start_released: assert property ($fell(sda_in) && scl_in
    |-> !sda_oe_dev)
    else $error("device pulling data at start condition");
  a_stop_released: assert property ($rose(sda_in) && scl_in
    |-> !sda_oe_dev && !sda_oe_host)
    else $error("data held at stop condition");
  a_scl_high_min: assert property ($rose(scl_in) |-> scl_in [*4])
    else $error("clock high phase too short");

  c_dev_pull: cover property ($rose(sda_oe_dev));
  c_start: cover property ($fell(sda_in) && scl_in);
  c_stop: cover property ($rose(sda_in) && scl_in);
endmodule

// *** test/i2c_current_dac_slave_port_tb.sv ***
// self-checking bench: master and dac port joined over the two-wire link
`timescale 1ns/10ps
`include "dac_link_map.svh"
module i2c_current_dac_slave_port_tb;
  import dac_link_pkg::*;
  // full-speed quarter period keeps the link within its bit rate limit
  localparam int unsigned QC = `DAC_LINK_QUARTER_CYC;
  logic          CLK_SYS   = 1'b0;
  logic          RESET_N   = 1'b0;
  logic          PD_PIN    = 1'b0;
  logic          REQ_VALID = 1'b0;
  logic          REQ_READ  = 1'b0;
  logic [6:0]    REQ_ADDR  = 7'h00;
  shift_word_t   REQ_WDATA = 16'h0000;
  logic          REQ_READY;
  logic          RSP_VALID;
  logic          RSP_NAK;
  logic          POWER_DOWN;
  shift_word_t   RSP_RDATA;
  shift_word_t   INPUT_SHIFT_BITS;
  current_code_t CURRENT_CODE;
  logic [26:0]   wire_bits = 27'h0;
  int            nbits     = 27;
  int            failures  = 0;
  int            cmp_count = 0;

  always #10 CLK_SYS = ~CLK_SYS;

  dac_link_if link ();
  dac_link_host #(.QUARTER_CYCLES(QC)) i_dac_link_host (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .LINK(link.host),
    .REQ_VALID(REQ_VALID), .REQ_READ(REQ_READ), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_NAK(RSP_NAK), .RSP_RDATA(RSP_RDATA));
  dac_link_device i_dac_link_device (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .LINK(link.device),
    .PD_PIN(PD_PIN), .POWER_DOWN(POWER_DOWN), .CURRENT_CODE(CURRENT_CODE),
    .INPUT_SHIFT_BITS(INPUT_SHIFT_BITS));
  dac_link_monitor i_dac_link_monitor (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .scl_out_host(link.scl_out_host), .scl_oe_host(link.scl_oe_host),
    .sda_out_host(link.sda_out_host), .sda_oe_host(link.sda_oe_host),
    .sda_out_dev(link.sda_out_dev), .sda_oe_dev(link.sda_oe_dev),
    .scl_in(link.scl_in), .sda_in(link.sda_in));

  // record the first 27 data-line samples after each start condition
  always @(negedge link.sda_in)
    if (link.scl_in === 1'b1) nbits = 0;
  always @(posedge link.scl_in)
    if (nbits < 27) begin
      wire_bits = {wire_bits[25:0], link.sda_in};
      nbits = nbits + 1;
    end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // address, direction, slave ack, then two bytes each with its ack
  function automatic logic [31:0] frame_of(input logic [6:0] a,
      input logic rd, input logic [15:0] d, input logic nak);
    return {5'h00, a, rd, nak, d[15:8], nak, d[7:0], nak};
  endfunction

  task automatic xfer(input logic rd, input logic [6:0] a,
                      input shift_word_t wd);
    int n;
    n = 0;
    @(negedge CLK_SYS);
    cmp_bit("ready idle", 1'b1, REQ_READY);
    REQ_VALID = 1'b1;
    REQ_READ  = rd;
    REQ_ADDR  = a;
    REQ_WDATA = wd;
    @(negedge CLK_SYS);
    REQ_VALID = 1'b0;
    cmp_bit("ready busy", 1'b0, REQ_READY);
    while (RSP_VALID !== 1'b1) begin
      @(negedge CLK_SYS);
      n++;
      if (n > 150 * QC) begin
        failures++;
        $display("FAIL rsp_valid expected 1 seen timeout");
        final_report();
      end
    end
    // start, three bytes of nine bits, stop: four quarters each
    cmp_val("cycles", 116 * QC, n);
    // let the device see the stop condition through its filters
    repeat (8) @(negedge CLK_SYS);
    cmp_bit("scl idle", 1'b1, link.scl_in);
    cmp_bit("sda idle", 1'b1, link.sda_in);
  endtask

  task automatic t_reset();
    cmp_val("code", 32'h0, {22'h0, CURRENT_CODE});
    cmp_val("input", 32'h0, {16'h0, INPUT_SHIFT_BITS});
    cmp_bit("power down", 1'b0, POWER_DOWN);
  endtask

  task automatic t_write_aliases();
    shift_word_t d [4] = '{16'h3ff0, 16'h4005, 16'h2a5f, 16'h1550};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 7'h0c + 7'(i), d[i]);
      cmp_val("frame", frame_of(7'h0c + 7'(i), 1'b0, d[i], 1'b0),
              {5'h0, wire_bits});
      cmp_bit("nak", 1'b0, RSP_NAK);
      cmp_val("code", {22'h0, d[i][13:4]}, {22'h0, CURRENT_CODE});
      cmp_val("input", {16'h0, d[i]}, {16'h0, INPUT_SHIFT_BITS});
      cmp_bit("power down", 1'b0, POWER_DOWN);
    end
  endtask

  task automatic t_power_down();
    xfer(1'b0, 7'h0c, 16'hbff0);
    cmp_bit("soft power down", 1'b1, POWER_DOWN);
    cmp_val("code", 32'h3ff, {22'h0, CURRENT_CODE});
    xfer(1'b0, 7'h0d, 16'h3ff0);
    cmp_bit("power up", 1'b0, POWER_DOWN);
    @(negedge CLK_SYS);
    PD_PIN = 1'b1;
    #2;
    cmp_bit("pin power down", 1'b1, POWER_DOWN);
    @(negedge CLK_SYS);
    PD_PIN = 1'b0;
    #2;
    cmp_bit("pin released", 1'b0, POWER_DOWN);
  endtask

  task automatic t_read();
    xfer(1'b1, 7'h0e, 16'h0000);
    cmp_val("read data", 32'h3ff0, {16'h0, RSP_RDATA});
    cmp_bit("read nak", 1'b0, RSP_NAK);
    cmp_val("frame", frame_of(7'h0e, 1'b1, 16'h3ff0, 1'b0),
            {5'h0, wire_bits});
    cmp_val("input", 32'h0, {16'h0, INPUT_SHIFT_BITS});
    cmp_val("code", 32'h3ff, {22'h0, CURRENT_CODE});
    xfer(1'b1, 7'h0f, 16'h0000);
    cmp_val("read again", 32'h0, {16'h0, RSP_RDATA});
  endtask

  task automatic t_foreign();
    xfer(1'b0, 7'h10, 16'h1230);
    cmp_bit("nak", 1'b1, RSP_NAK);
    cmp_val("frame", frame_of(7'h10, 1'b0, 16'h1230, 1'b1),
            {5'h0, wire_bits});
    cmp_val("code", 32'h3ff, {22'h0, CURRENT_CODE});
    xfer(1'b0, 7'h0c, 16'h0120);
    cmp_val("code after", 32'h012, {22'h0, CURRENT_CODE});
  endtask

  task automatic t_mid_reset();
    xfer(1'b0, 7'h0c, 16'hbff0);
    cmp_bit("soft power down", 1'b1, POWER_DOWN);
    @(negedge CLK_SYS);
    RESET_N = 1'b0;
    #2;
    cmp_bit("reset power down", 1'b0, POWER_DOWN);
    cmp_val("reset code", 32'h0, {22'h0, CURRENT_CODE});
    cmp_val("reset input", 32'h0, {16'h0, INPUT_SHIFT_BITS});
    repeat (12) @(negedge CLK_SYS);
    RESET_N = 1'b1;
    cmp_bit("ready after reset", 1'b1, REQ_READY);
    xfer(1'b1, 7'h0d, 16'h0000);
    cmp_bit("nak after reset", 1'b0, RSP_NAK);
    cmp_val("read after reset", 32'h0, {16'h0, RSP_RDATA});
  endtask

  initial begin
    repeat (12) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RESET_N = 1'b1;
    t_reset();
    t_write_aliases();
    t_power_down();
    t_read();
    t_foreign();
    t_mid_reset();
    final_report();
  end
endmodule
